// File: hdl/lpddr_pkg.sv
`default_nettype none
package lpddr_pkg;

   // ==========================================================================
   // register map (byte addresses, one word each)
   localparam logic [3:0]  REG_CONTROL   = 4'h0;
   localparam logic [3:0]  REG_STATUS    = 4'h4;
   localparam logic [3:0]  REG_MODE      = 4'h8;
   localparam logic [3:0]  REG_EXT_MODE  = 4'hc;
   localparam int          WP_BIT        = 0;
   localparam logic        WP_RESET      = 1'b0;

   // status field positions
   localparam int          ST_POWER_LSB  = 0;
   localparam int          ST_SR_BIT     = 2;
   localparam int          ST_OPEN_LSB   = 4;

   // ==========================================================================
   // command code {select_n, row_n, column_n, write_n}
   localparam logic [3:0]  CMD_LOAD_MODE  = 4'h0;
   localparam logic [3:0]  CMD_REFRESH    = 4'h1;
   localparam logic [3:0]  CMD_PRECHARGE  = 4'h2;
   localparam logic [3:0]  CMD_ACTIVATE   = 4'h3;
   localparam logic [3:0]  CMD_WRITE      = 4'h4;
   localparam logic [3:0]  CMD_READ       = 4'h5;
   localparam logic [3:0]  CMD_BURST_STOP = 4'h6;

   localparam int          PRECHARGE_SCOPE_POS = 10;
   localparam logic [1:0]  BANK_STD_MODE = 2'h0;
   localparam logic [1:0]  BANK_EXT_MODE = 2'h2;

   // ==========================================================================
   // mode register fields and reset values
   localparam int          BL_LSB        = 0;
   localparam int          CL_LSB        = 4;
   localparam logic [2:0]  BL_CODE_2     = 3'h1;
   localparam logic [2:0]  BL_CODE_4     = 3'h2;
   localparam logic [2:0]  BL_CODE_8     = 3'h3;
   localparam logic [12:0] MODE_RESET    = 13'h0032;
   localparam logic [12:0] EXT_MODE_RESET = 13'h0000;

   // ==========================================================================
   // write strobe to first data edge, in link cycles
   localparam logic        WRITE_LATENCY = 1'b1;

   // storage window: bank plus low column bits
   localparam int          STORE_COL_BITS = 6;
   localparam int          STORE_DEPTH    = 256;
   localparam int          SNAP_W         = 33;

   typedef enum logic [1:0] {PWR_ON, PWR_PRE_PD, PWR_ACT_PD} power_t;

endpackage : lpddr_pkg
`default_nettype wire

// File: hdl/lpddr_pin_command_interface.sv
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Function
// - commands registered on rising clock crossing only
// - data moves on both clock edges
// - clock gate low stops decoding and drivers
// - gate low enters precharge or active power-down
// - self refresh exit recognised asynchronously
// - power-down ignores every input but gate
// - select low enables decoder, high masks
// - masked write bytes are discarded
// - low mask lower byte, high mask upper
// - bank select steers activate read write precharge
// - bank select picks mode or extended mode
// - address gives column and auto-precharge bit, row ignored
// - precharge closes one bank or all
// - mode load takes opcode from address
// - sixteen-bit two-way data bus
// - strobe edge-aligned with read data
// - bursts of two, four or eight
module lpddr_pin_command_interface
   import lpddr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic        ck,
   input  wire logic        clock_gate_in,
   input  wire logic        device_select_n,
   input  wire logic        row_strobe_n,
   input  wire logic        column_strobe_n,
   input  wire logic        write_strobe_n,
   input  wire logic [1:0]  bank_sel,
   input  wire logic [12:0] addr,
   input  wire logic        low_byte_mask,
   input  wire logic        high_byte_mask,
   input  wire logic [15:0] dq_in,
   output logic      [15:0] dq_out,
   output logic             dq_oe,
   output logic      [1:0]  dqs_out,
   output logic             dqs_oe
);

   // =========================================================================
   // state types
   typedef struct packed {
      power_t              power;
      logic                cke_prev;
      logic [3:0]          open;
      logic [12:0]         mode;
      logic [12:0]         ext_mode;
      logic                wp_s1;
      logic                wp_s2;
      logic                ack_s1;
      logic                ack_s2;
      logic                req;
      logic [SNAP_W-1:0]   snap;
      logic                rd_act;
      logic [2:0]          rd_wait;
      logic [1:0]          rd_bank;
      logic [5:0]          rd_col;
      logic [2:0]          rd_beat;
      logic [2:0]          rd_left;
      logic                rd_ap;
      logic                drive;
      logic [15:0]         q_even;
      logic [15:0]         q_odd;
      logic                wr_act;
      logic                wr_wait;
      logic [1:0]          wr_bank;
      logic [5:0]          wr_col;
      logic [2:0]          wr_beat;
      logic [2:0]          wr_left;
      logic                wr_ap;
   } link_t;

   typedef struct packed {
      logic                wp;
      logic                served;
      logic [31:0]         readdata;
      logic                req_s1;
      logic                req_s2;
      logic                ack;
      logic [SNAP_W-1:0]   status;
   } bus_t;

   link_t               lq;
   link_t               next_lq;
   bus_t                bq;
   bus_t                next_bq;
   logic [1:0]          lrst_q;
   logic                lrst_n;
   logic                sr_active;
   logic                sr_clr_n;
   logic                sr_go;
   logic                run;
   logic                cmd_ok;
   logic [3:0]          cmd;
   logic [15:0]         neg_dq;
   logic [1:0]          neg_mask;
   logic [15:0]         dq_neg;
   logic [15:0]         rd_even;
   logic [15:0]         rd_odd;
   logic [7:0]          rd_a0;
   logic [7:0]          rd_a1;
   logic [7:0]          wr_a0;
   logic [7:0]          wr_a1;
   logic                wr_commit;
   logic [1:0]          we_even;
   logic [1:0]          we_odd;
   logic [2:0]          bl_m;
   logic [SNAP_W-1:0]   live;

   // =========================================================================
   // burst helpers
   function automatic logic [2:0] burst_mask(input logic [2:0] code);
      case (code)
         BL_CODE_2: burst_mask = 3'h1;
         BL_CODE_8: burst_mask = 3'h7;
         default:   burst_mask = 3'h3;
      endcase
   endfunction : burst_mask

   // sequential order wrapping inside the burst-aligned block
   function automatic logic [5:0] beat_col(input logic [5:0] start,
                                           input logic [2:0] beat,
                                           input logic [2:0] m);
      logic [2:0] sum;
      sum = 3'(start[2:0] + beat);
      beat_col = {start[5:3], (start[2:0] & ~m) | (sum & m)};
   endfunction : beat_col

   // =========================================================================
   // link reset release, synchronous to the link clock
   always_ff @(posedge ck or negedge rstn)
   begin
      if (!rstn)
         lrst_q <= 2'h0;
      else
         lrst_q <= {lrst_q[0], 1'b1};
   end
   assign lrst_n = lrst_q[1];

   // =========================================================================
   // command decode, sampled on the rising crossing
   assign cmd    = {device_select_n, row_strobe_n, column_strobe_n,
                    write_strobe_n};
   // gate must be high now and at the previous edge
   assign run    = (lq.power == PWR_ON) && !sr_active && lq.cke_prev
                   && clock_gate_in;
   assign cmd_ok = run && !device_select_n;
   assign sr_go  = (lq.power == PWR_ON) && !sr_active && lq.cke_prev
                   && !clock_gate_in && !device_select_n
                   && (cmd == CMD_REFRESH) && (lq.open == 4'h0);
   assign bl_m   = burst_mask(lq.mode[BL_LSB +: 3]);

   // self refresh ends on the gate level itself, clock may be stopped
   assign sr_clr_n = lrst_n & ~clock_gate_in;
   always_ff @(posedge ck or negedge sr_clr_n)
   begin
      if (!sr_clr_n)
         sr_active <= 1'b0;
      else if (sr_go)
         sr_active <= 1'b1;
   end

   // =========================================================================
   // storage, one array per byte lane
   assign rd_a0 = {lq.rd_bank, beat_col(lq.rd_col, lq.rd_beat, bl_m)};
   assign rd_a1 = {lq.rd_bank,
                   beat_col(lq.rd_col, 3'(lq.rd_beat + 3'h1), bl_m)};
   assign wr_a0 = {lq.wr_bank, beat_col(lq.wr_col, lq.wr_beat, bl_m)};
   assign wr_a1 = {lq.wr_bank,
                   beat_col(lq.wr_col, 3'(lq.wr_beat + 3'h1), bl_m)};
   assign wr_commit = run && lq.wr_act && !lq.wr_wait;
   // first beat from the falling edge, second from this rising edge
   assign we_even = {2{wr_commit && !lq.wp_s2}} & ~neg_mask;
   assign we_odd  = {2{wr_commit && !lq.wp_s2}}
                    & ~{high_byte_mask, low_byte_mask};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_lane
         logic [7:0] lane [0:STORE_DEPTH-1];
         always_ff @(posedge ck)
         begin
            if (we_even[gi])
               lane[wr_a0] <= neg_dq[gi*8 +: 8];
            if (we_odd[gi])
               lane[wr_a1] <= dq_in[gi*8 +: 8];
         end
         assign rd_even[gi*8 +: 8] = lane[rd_a0];
         assign rd_odd[gi*8 +: 8]  = lane[rd_a1];
      end
   endgenerate

   // =========================================================================
   // falling-edge half of the double data rate path
   always_ff @(negedge ck or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         neg_dq   <= 16'h0000;
         neg_mask <= 2'h3;
         dq_neg   <= 16'h0000;
      end
      else
      begin
         neg_dq   <= dq_in;
         neg_mask <= {high_byte_mask, low_byte_mask};
         dq_neg   <= lq.q_odd;
      end
   end

   // clock-level mux: even word while ck high, odd word while ck low
   assign dq_out  = ck ? lq.q_even : dq_neg;
   assign dq_oe   = lq.drive;
   assign dqs_out = {2{ck & lq.drive}};
   assign dqs_oe  = lq.drive;

   // =========================================================================
   // link state
   assign live = {lq.ext_mode, lq.mode, lq.open, sr_active, lq.power};

   always_comb
   begin
      next_lq          = lq;
      next_lq.cke_prev = clock_gate_in;
      next_lq.wp_s1    = bq.wp;
      next_lq.wp_s2    = lq.wp_s1;
      next_lq.ack_s1   = bq.ack;
      next_lq.ack_s2   = lq.ack_s1;
      next_lq.drive    = 1'b0;
      // read burst engine
      if (run && lq.rd_act)
      begin
         if (lq.rd_wait > 3'h1)
            next_lq.rd_wait = 3'(lq.rd_wait - 3'h1);
         else
         begin
            next_lq.q_even  = rd_even;
            next_lq.q_odd   = rd_odd;
            next_lq.drive   = 1'b1;
            next_lq.rd_beat = 3'(lq.rd_beat + 3'h2);
            next_lq.rd_left = 3'(lq.rd_left - 3'h1);
            if (lq.rd_left == 3'h1)
            begin
               next_lq.rd_act = 1'b0;
               if (lq.rd_ap)
                  next_lq.open[lq.rd_bank] = 1'b0;
            end
         end
      end
      // write burst engine
      if (run && lq.wr_act)
      begin
         if (lq.wr_wait)
            next_lq.wr_wait = 1'b0;
         else
         begin
            next_lq.wr_beat = 3'(lq.wr_beat + 3'h2);
            next_lq.wr_left = 3'(lq.wr_left - 3'h1);
            if (lq.wr_left == 3'h1)
            begin
               next_lq.wr_act = 1'b0;
               if (lq.wr_ap)
                  next_lq.open[lq.wr_bank] = 1'b0;
            end
         end
      end
      // commands; a new access cuts any burst in flight
      if (cmd_ok)
      begin
         case (cmd)
            CMD_ACTIVATE:
               next_lq.open[bank_sel] = 1'b1;
            CMD_READ:
            begin
               if (lq.open[bank_sel])
               begin
                  next_lq.rd_act  = 1'b1;
                  next_lq.wr_act  = 1'b0;
                  next_lq.rd_wait = lq.mode[CL_LSB +: 3];
                  next_lq.rd_bank = bank_sel;
                  next_lq.rd_col  = addr[STORE_COL_BITS-1:0];
                  next_lq.rd_beat = 3'h0;
                  next_lq.rd_left = 3'((4'(bl_m) + 4'h1) >> 1);
                  next_lq.rd_ap   = addr[PRECHARGE_SCOPE_POS];
               end
            end
            CMD_WRITE:
            begin
               if (lq.open[bank_sel])
               begin
                  next_lq.wr_act  = 1'b1;
                  next_lq.rd_act  = 1'b0;
                  next_lq.wr_wait = WRITE_LATENCY;
                  next_lq.wr_bank = bank_sel;
                  next_lq.wr_col  = addr[STORE_COL_BITS-1:0];
                  next_lq.wr_beat = 3'h0;
                  next_lq.wr_left = 3'((4'(bl_m) + 4'h1) >> 1);
                  next_lq.wr_ap   = addr[PRECHARGE_SCOPE_POS];
               end
            end
            CMD_PRECHARGE:
            begin
               if (addr[PRECHARGE_SCOPE_POS])
                  next_lq.open = 4'h0;
               else
                  next_lq.open[bank_sel] = 1'b0;
            end
            CMD_LOAD_MODE:
            begin
               if (bank_sel == BANK_STD_MODE)
                  next_lq.mode = addr;
               else if (bank_sel == BANK_EXT_MODE)
                  next_lq.ext_mode = addr;
            end
            CMD_BURST_STOP:
               next_lq.rd_act = 1'b0;
            default:
               ;
         endcase
      end
      // power-down entry and exit
      case (lq.power)
         PWR_ON:
         begin
            if (lq.cke_prev && !clock_gate_in && !sr_go && !sr_active)
            begin
               next_lq.power  = (lq.open == 4'h0) ? PWR_PRE_PD
                                                  : PWR_ACT_PD;
               next_lq.rd_act = 1'b0;
               next_lq.wr_act = 1'b0;
            end
         end
         PWR_PRE_PD, PWR_ACT_PD:
         begin
            if (clock_gate_in)
               next_lq.power = PWR_ON;
         end
         default:
            next_lq.power = PWR_ON;
      endcase
      // status snapshot, toggle handshake toward the bus clock
      if ((lq.req == lq.ack_s2) && (live != lq.snap))
      begin
         next_lq.snap = live;
         next_lq.req  = ~lq.req;
      end
   end

   always_ff @(posedge ck or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         lq          <= '0;
         lq.mode     <= MODE_RESET;
         lq.ext_mode <= EXT_MODE_RESET;
      end
      else
         lq <= next_lq;
   end

   // =========================================================================
   // register slave, one wait cycle per access
   assign waitrequest = (read | write) & ~bq.served;
   assign readdata    = bq.readdata;

   always_comb
   begin
      next_bq        = bq;
      next_bq.served = (read | write) & ~bq.served;
      next_bq.req_s1 = lq.req;
      next_bq.req_s2 = bq.req_s1;
      // snapshot is frozen until ack returns, safe to sample whole
      if (bq.req_s2 != bq.ack)
      begin
         next_bq.status = lq.snap;
         next_bq.ack    = bq.req_s2;
      end
      if (read && !bq.served)
      begin
         case (address)
            REG_CONTROL:
               next_bq.readdata = {31'h0, bq.wp};
            REG_STATUS:
               next_bq.readdata = {24'h0, bq.status[6:3], 1'b0,
                                   bq.status[2:0]};
            REG_MODE:
               next_bq.readdata = {19'h0, bq.status[19:7]};
            REG_EXT_MODE:
               next_bq.readdata = {19'h0, bq.status[32:20]};
            default:
               next_bq.readdata = 32'h0;
         endcase
      end
      if (write && bq.served && (address == REG_CONTROL) && byteenable[0])
         next_bq.wp = writedata[WP_BIT];
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bq    <= '0;
         bq.wp <= WP_RESET;
      end
      else
         bq <= next_bq;
   end

   // =========================================================================
   // checks
   a_act_opens: assert property (
      @(posedge ck) disable iff (!lrst_n)
      (cmd_ok && cmd == CMD_ACTIVATE) |=> lq.open[$past(bank_sel)])
      else $error("activate did not open bank");

   a_pre_all: assert property (
      @(posedge ck) disable iff (!lrst_n)
      (cmd_ok && cmd == CMD_PRECHARGE && addr[PRECHARGE_SCOPE_POS])
      |=> (lq.open == 4'h0))
      else $error("precharge all left a bank open");

   a_pre_one: assert property (
      @(posedge ck) disable iff (!lrst_n)
      (cmd_ok && cmd == CMD_PRECHARGE && !addr[PRECHARGE_SCOPE_POS])
      |=> !lq.open[$past(bank_sel)])
      else $error("single precharge left bank open");

   a_mode_load: assert property (
      @(posedge ck) disable iff (!lrst_n)
      (cmd_ok && cmd == CMD_LOAD_MODE && bank_sel == BANK_STD_MODE)
      |=> (lq.mode == $past(addr)) && $stable(lq.ext_mode))
      else $error("mode load wrong register or value");

   a_select_masks: assert property (
      @(posedge ck) disable iff (!lrst_n)
      device_select_n |=> $stable(lq.mode) && $stable(lq.ext_mode))
      else $error("deselected command changed mode");

   a_active_pd: assert property (
      @(posedge ck) disable iff (!lrst_n)
      (lq.power == PWR_ON && lq.cke_prev && !clock_gate_in && !sr_active
       && !sr_go && lq.open != 4'h0) |=> (lq.power == PWR_ACT_PD))
      else $error("open row did not enter active power-down");

   a_pd_quiet: assert property (
      @(posedge ck) disable iff (!lrst_n)
      (lq.power != PWR_ON || sr_active) |=> !dq_oe [*2])
      else $error("drivers on during power-down");

   a_sr_exit: assert property (
      @(posedge ck) disable iff (!lrst_n)
      clock_gate_in |-> !sr_active)
      else $error("self refresh held with gate high");

   a_read_cl3: assert property (
      @(posedge ck) disable iff (!lrst_n)
      (cmd_ok && cmd == CMD_READ && lq.open[bank_sel]
       && lq.mode[CL_LSB +: 3] == 3'h3)
      ##1 (clock_gate_in && (device_select_n || cmd == 4'h7)) [*3]
      |=> dq_oe)
      else $error("read data not driven after latency");

   a_bus_wait: assert property (
      @(posedge clk) disable iff (!rstn)
      ((read || write) && waitrequest) |=> !waitrequest || !(read || write))
      else $error("slave held waitrequest over one cycle");

endmodule : lpddr_pin_command_interface

`default_nettype wire

// File: test/ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// controller side of the link
module ctrl
   import lpddr_pkg::*;
(
   output var logic        ck,
   output var logic        clock_gate_in,
   output var logic        device_select_n,
   output var logic        row_strobe_n,
   output var logic        column_strobe_n,
   output var logic        write_strobe_n,
   output var logic [1:0]  bank_sel,
   output var logic [12:0] addr,
   output var logic        low_byte_mask,
   output var logic        high_byte_mask,
   output var logic [15:0] dq_drv
);
   initial
   begin
      ck = 1'b0;
      clock_gate_in = 1'b1;
      {device_select_n, row_strobe_n, column_strobe_n, write_strobe_n} = 4'h7;
      bank_sel = 2'h0;
      addr = 13'h0;
      {high_byte_mask, low_byte_mask} = 2'h0;
      dq_drv = 16'h0;
      // odd offset keeps the link out of phase with clk
      #3;
      forever #24 ck = ~ck;
   end

   task cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
      @(posedge ck);
      {device_select_n, row_strobe_n, column_strobe_n, write_strobe_n} <= c;
      bank_sel <= b;
      addr <= a;
      @(posedge ck);
      {device_select_n, row_strobe_n, column_strobe_n, write_strobe_n} <= 4'h7;
      bank_sel <= ~b;
      addr <= ~a;
   endtask : cmd

   task wdat(input logic [15:0] w0, w1, input logic [1:0] m0, m1);
      dq_drv <= w0;
      {high_byte_mask, low_byte_mask} <= m0;
      @(posedge ck);
      @(negedge ck);
      dq_drv <= w1;
      {high_byte_mask, low_byte_mask} <= m1;
      @(posedge ck);
      dq_drv <= ~w1;
      {high_byte_mask, low_byte_mask} <= 2'h0;
   endtask : wdat

   task pdn(input logic g, input logic [3:0] c);
      @(posedge ck);
      clock_gate_in <= g;
      {device_select_n, row_strobe_n, column_strobe_n, write_strobe_n} <= c;
      @(posedge ck);
      {device_select_n, row_strobe_n, column_strobe_n, write_strobe_n} <= 4'h7;
   endtask : pdn

   // self refresh exit lands between edges on purpose
   task wake;
      @(negedge ck);
      #5;
      clock_gate_in <= 1'b1;
   endtask : wake
endmodule : ctrl
`default_nettype wire

// File: test/lpddr_pin_command_interface_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lpddr_pin_command_interface_tb
   import lpddr_pkg::*;
;
   logic        clk, rstn, read, write, dq_oe, dqs_oe, waitrequest;
   logic [3:0]  address;
   logic [31:0] writedata, readdata;
   logic        ck, clock_gate_in, device_select_n, row_strobe_n;
   logic        column_strobe_n, write_strobe_n, low_byte_mask, high_byte_mask;
   logic [1:0]  bank_sel, dqs_out;
   logic [12:0] addr, x;
   logic [15:0] dq_drv, dq_out, w0, w1, v0, v1, e16;
   logic [63:0] e;
   logic [63:0] rq[$];
   logic [15:0] dq_q[$];
   int          failures, checked;
   wire logic [15:0] dq_in;

   assign dq_in = (dq_oe === 1'b1) ? dq_out : dq_drv;

   lpddr_pin_command_interface u_lpddr_pin_command_interface (.clk(clk),
      .rstn(rstn), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
      .waitrequest(waitrequest), .ck(ck), .clock_gate_in(clock_gate_in),
      .device_select_n(device_select_n), .row_strobe_n(row_strobe_n),
      .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
      .bank_sel(bank_sel), .addr(addr), .low_byte_mask(low_byte_mask),
      .high_byte_mask(high_byte_mask), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe));

   ctrl u_ctrl (.ck(ck), .clock_gate_in(clock_gate_in),
      .device_select_n(device_select_n), .row_strobe_n(row_strobe_n),
      .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
      .bank_sel(bank_sel), .addr(addr), .low_byte_mask(low_byte_mask),
      .high_byte_mask(high_byte_mask), .dq_drv(dq_drv));

   // ====
   // checks
   task chk(input logic [31:0] got, ex, m);
      checked++;
      if ((got & m) !== (ex & m))
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got & m, ex & m);
      end
   endtask : chk

   task wrap_up;
      // expected words never seen count as mismatches
      failures += dq_q.size() + rq.size();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   // an empty queue makes any driven word a mismatch
   task dqchk(input logic [1:0] s);
      e16 = (dq_q.size() > 0) ? dq_q.pop_front() : ~dq_out;
      chk(32'({dqs_oe, dqs_out, dq_out}), 32'({1'b1, s, e16}), 32'h7ffff);
   endtask : dqchk

   always @(posedge ck)
   begin
      #12;
      if (dq_oe === 1'b1)
         dqchk(2'b11);
   end

   always @(negedge ck)
   begin
      #12;
      if (dq_oe === 1'b1)
         dqchk(2'b00);
   end

   always @(negedge clk)
      if (read === 1'b1 && waitrequest === 1'b0)
      begin
         e = rq.pop_front();
         chk(readdata, e[31:0], e[63:32]);
      end

   // ====
   // stimulus
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, m);
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      if (!wr)
         rq.push_back({m, d});
      // only the watchdog ends a wait that never gets an answer
      do
         @(posedge clk);
      while (waitrequest !== 1'b0);
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task settle;
      repeat (12) @(posedge ck);
   endtask : settle

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      #200000;
      failures++;
      wrap_up();
   end

   initial
   begin
      {rstn, read, write, address, writedata} = '0;
      failures = 0;
      checked = 0;
      x = 13'($urandom(32'h1ac61489));
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      settle();
      bus(0, REG_CONTROL, 32'h0, '1);
      bus(0, REG_MODE, 32'(MODE_RESET), '1);
      bus(0, REG_EXT_MODE, 32'(EXT_MODE_RESET), '1);
      bus(0, 4'h1, 32'h0, '1);
      bus(0, REG_STATUS, 32'h0, 32'hff);
      u_ctrl.cmd(CMD_LOAD_MODE, BANK_STD_MODE, 13'h30 | 13'(BL_CODE_2));
      u_ctrl.cmd(CMD_LOAD_MODE, BANK_EXT_MODE, x);
      u_ctrl.cmd(CMD_LOAD_MODE, 2'h1, ~x);
      settle();
      bus(0, REG_MODE, 32'h31, '1);
      bus(0, REG_EXT_MODE, 32'(x), '1);
      {w0, w1} = $urandom();
      {v0, v1} = $urandom();
      u_ctrl.cmd(CMD_ACTIVATE, 2'h1, x);
      u_ctrl.cmd(CMD_WRITE, 2'h1, 13'h0004);
      u_ctrl.wdat(w0, w1, 2'h0, 2'h0);
      u_ctrl.cmd(CMD_WRITE, 2'h1, 13'h0004);
      u_ctrl.wdat(v0, v1, 2'h1, 2'h2);
      bus(1, REG_CONTROL, 32'h1, 0);
      bus(0, REG_CONTROL, 32'h1, '1);
      settle();
      u_ctrl.cmd(CMD_WRITE, 2'h1, 13'h0004);
      u_ctrl.wdat(~w0, ~w1, 2'h0, 2'h0);
      bus(1, REG_CONTROL, 32'h0, 0);
      settle();
      dq_q.push_back({v0[15:8], w0[7:0]});
      dq_q.push_back({w1[15:8], v1[7:0]});
      u_ctrl.cmd(CMD_READ, 2'h1, 13'h0004);
      settle();
      u_ctrl.cmd(CMD_READ | 4'h8, 2'h1, 13'h0004);
      u_ctrl.cmd(CMD_PRECHARGE | 4'h8, 2'h1, 13'h0400);
      u_ctrl.pdn(1'b0, 4'h7);
      settle();
      bus(0, REG_STATUS, 32'h22, 32'hff);
      u_ctrl.cmd(CMD_PRECHARGE, 2'h1, 13'h0400);
      u_ctrl.pdn(1'b1, 4'h7);
      settle();
      bus(0, REG_STATUS, 32'h20, 32'hff);
      u_ctrl.cmd(CMD_PRECHARGE, 2'h0, 13'h0000);
      settle();
      bus(0, REG_STATUS, 32'h20, 32'hff);
      u_ctrl.cmd(CMD_PRECHARGE, 2'h2, 13'h0400);
      u_ctrl.cmd(CMD_READ, 2'h1, 13'h0004);
      settle();
      bus(0, REG_STATUS, 32'h0, 32'hff);
      u_ctrl.pdn(1'b0, CMD_REFRESH);
      settle();
      bus(0, REG_STATUS, 32'h4, 32'h4);
      u_ctrl.wake();
      settle();
      bus(0, REG_STATUS, 32'h0, 32'h7);
      u_ctrl.pdn(1'b0, 4'h7);
      settle();
      bus(0, REG_STATUS, 32'h1, 32'hff);
      u_ctrl.pdn(1'b1, 4'h7);
      settle();
      wrap_up();
   end
endmodule : lpddr_pin_command_interface_tb
`default_nettype wire
